// ### rtl/switch_pkg.sv
//------------------------------------------------------------------------------
// Notes on behaviour
// RULE_01: Upstream clock/data pair connects to any subset of four channel pairs.
// RULE_02: Combined interrupt output is the AND of four active-low inputs.
// RULE_03: Reset pin or power-on reset idles the slave and deselects all.
// RULE_04: After power-up all four downstream channels are disconnected.
// RULE_05: Two address pins form the low slave address bits; board ties them.
// RULE_06: Last address bit 1 means read, 0 means write.
// RULE_07: Each written data byte is stored; the last one wins.
// RULE_08: Control register is writable and readable over the serial bus.
// RULE_09: Bits zero to three enable their channel; any combination allowed.
// RULE_10: New channel selection becomes active only after a STOP.
// RULE_11: Interrupt inputs are seen whether or not their channel is enabled.
// RULE_12: Bits four to seven report interrupts of channels zero to three.
// RULE_13: A read loads current interrupt inputs; 1 means asserted.
// RULE_14: Combined interrupt output is open-drain, pulled low on any interrupt.
// RULE_15: Master reads status, enables channel, queries every device there.
// RULE_16: Interrupt inputs double as general inputs readable in status bits.
// RULE_17: Serial slave works from zero up to 400 kHz clock rate.
// RULE_18: Device acknowledges address and each received byte by pulling low.
// RULE_19: Reset pin held low long enough clears registers, state, channels.
// RULE_20: Released power-on reset leaves control register all zero.
// RULE_21: Fixed upper address bits plus pin bits; only a match is acked.
// RULE_22: Writes to the status bits are ignored; reads show sampled inputs.
//------------------------------------------------------------------------------
package switch_pkg;

  //----------------------------------------------------------------------------
  // Sizes and timing
  //----------------------------------------------------------------------------
  localparam int         CHANNELS       = 4;
  localparam int         CLK_PERIOD_NS  = 8;
  // Guard time after releasing a line, longer than pad plus sync lag
  localparam int         SETTLE_TIME_NS = 40;
  localparam int         SETTLE_CYC     =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_LOAD    = 3'(SETTLE_CYC);
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] BIT_FIRST      = 3'h0;

  //----------------------------------------------------------------------------
  // Addressing
  //----------------------------------------------------------------------------
  localparam logic [4:0] ADDR_FIXED     = 5'h15;
  localparam logic       RW_READ        = 1'b1;

  //----------------------------------------------------------------------------
  // Control byte layout
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] irq_stat;
    logic [3:0] chan_sel;
  } ctrl_byte_t;

  localparam ctrl_byte_t CTRL_RESET = '{irq_stat: 4'h0, chan_sel: 4'h0};
  localparam logic [3:0] SEL_NONE   = 4'h0;

  //----------------------------------------------------------------------------
  // State machines
  //----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WR_DATA,
    S_WR_ACK,
    S_RD_DATA,
    S_RD_ACK
  } slave_state_t;

  typedef enum logic [1:0] {
    R_IDLE,
    R_UP_OWNS,
    R_DN_OWNS,
    R_SETTLE
  } rpt_state_t;

  function automatic logic addr_match(input logic [6:0] addr7,
                                      input logic [1:0] pins);
    return addr7 == {ADDR_FIXED, pins};
  endfunction : addr_match

endpackage : switch_pkg

// ### rtl/line_repeater.sv
`timescale 1ns/1ns
module line_repeater #(
  parameter int CHANS = switch_pkg::CHANNELS
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic             up_in,
  input  wire logic             local_low_in,
  input  wire logic [CHANS-1:0] dn_in,
  input  wire logic [CHANS-1:0] en_in,
  output logic                  up_oe_n_out,
  output logic      [CHANS-1:0] dn_oe_n_out,
  output logic                  up_level_out
);

  //----------------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------------
  logic                    up_meta_reg;
  logic                    up_sync_reg;
  logic [CHANS-1:0]        dn_meta_reg;
  logic [CHANS-1:0]        dn_sync_reg;
  switch_pkg::rpt_state_t  state_reg;
  switch_pkg::rpt_state_t  state_next;
  logic [2:0]              settle_reg;
  logic [2:0]              settle_next;
  logic                    up_oe_n_reg;
  logic [CHANS-1:0]        dn_oe_n_reg;
  wire logic               dn_low_any;

  always_ff @(posedge ref_clk_in)
  begin
    up_meta_reg <= up_in;
    up_sync_reg <= up_meta_reg;
    dn_meta_reg <= dn_in;
    dn_sync_reg <= dn_meta_reg;
  end

  // Disabled channels are invisible to the upstream side
  assign dn_low_any = |(~dn_sync_reg & en_in); // RULE_01

  //----------------------------------------------------------------------------
  // Ownership of the low level
  //----------------------------------------------------------------------------
  // Whichever side pulled low first owns the line until it lets go; the
  // settle window stops our own release from echoing back as a new low.
  always_comb
  begin
    state_next  = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      switch_pkg::R_IDLE:
      begin
        if (!up_sync_reg)
          state_next = switch_pkg::R_UP_OWNS;
        else if (dn_low_any)
          state_next = switch_pkg::R_DN_OWNS;
      end
      switch_pkg::R_UP_OWNS:
      begin
        if (up_sync_reg)
        begin
          state_next  = switch_pkg::R_SETTLE;
          settle_next = switch_pkg::SETTLE_LOAD; // RULE_17
        end
      end
      switch_pkg::R_DN_OWNS:
      begin
        if (!dn_low_any)
        begin
          state_next  = switch_pkg::R_SETTLE;
          settle_next = switch_pkg::SETTLE_LOAD; // RULE_17
        end
      end
      switch_pkg::R_SETTLE:
      begin
        if (settle_reg == 3'h0)
          state_next = switch_pkg::R_IDLE;
        else
          settle_next = settle_reg - 3'h1;
      end
      default:
        state_next = switch_pkg::R_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_reg   <= switch_pkg::R_IDLE;
      settle_reg  <= 3'h0;
      up_oe_n_reg <= 1'b1;
      dn_oe_n_reg <= {CHANS{1'b1}};
    end
    else
    begin
      state_reg   <= state_next;
      settle_reg  <= settle_next;
      up_oe_n_reg <= ~(local_low_in |
                       (state_next == switch_pkg::R_DN_OWNS));
      dn_oe_n_reg <= ~({CHANS{state_next == switch_pkg::R_UP_OWNS}}
                       & en_in); // RULE_01
    end
  end

  assign up_oe_n_out  = up_oe_n_reg;
  assign dn_oe_n_out  = dn_oe_n_reg;
  assign up_level_out = up_sync_reg;

endmodule : line_repeater

// ### rtl/i2c_four_channel_switch_ctrl.sv
`timescale 1ns/1ns
module i2c_four_channel_switch_ctrl #(
  parameter int CHANS = switch_pkg::CHANNELS
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic             rst_pin_n_in,
  input  wire logic             addr_pin_lo_in,
  input  wire logic             addr_pin_hi_in,
  input  wire logic             irq_in_ch0_n_in,
  input  wire logic             irq_in_ch1_n_in,
  input  wire logic             irq_in_ch2_n_in,
  input  wire logic             irq_in_ch3_n_in,
  input  wire logic             up_scl_in,
  output logic                  up_scl_out,
  output logic                  up_scl_oe_n_out,
  input  wire logic             up_sda_in,
  output logic                  up_sda_out,
  output logic                  up_sda_oe_n_out,
  input  wire logic [CHANS-1:0] down_clk_line_in,
  output logic      [CHANS-1:0] down_clk_line_out,
  output logic      [CHANS-1:0] down_clk_line_oe_n_out,
  input  wire logic [CHANS-1:0] down_dat_line_in,
  output logic      [CHANS-1:0] down_dat_line_out,
  output logic      [CHANS-1:0] down_dat_line_oe_n_out,
  output logic                  irq_n_out,
  output logic                  irq_oe_n_out,
  output logic      [CHANS-1:0] active_sel_out
);

  //----------------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------------
  logic                      rst_pin_meta_reg;
  logic                      rst_pin_sync_reg;
  logic                      rst_hold_reg;
  logic [3:0]                irq_meta_reg;
  logic [3:0]                irq_sync_reg;
  logic [1:0]                addr_meta_reg;
  logic [1:0]                addr_sync_reg;
  wire logic                 rst_all;
  wire logic [3:0]           irq_now;

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      rst_pin_meta_reg <= 1'b1;
      rst_pin_sync_reg <= 1'b1;
      rst_hold_reg     <= 1'b1;
    end
    else
    begin
      rst_pin_meta_reg <= rst_pin_n_in;
      rst_pin_sync_reg <= rst_pin_meta_reg;
      rst_hold_reg     <= ~rst_pin_sync_reg; // RULE_19
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    irq_meta_reg  <= {irq_in_ch3_n_in, irq_in_ch2_n_in,
                      irq_in_ch1_n_in, irq_in_ch0_n_in};
    irq_sync_reg  <= irq_meta_reg;
    addr_meta_reg <= {addr_pin_hi_in, addr_pin_lo_in};
    addr_sync_reg <= addr_meta_reg;
  end

  // Either reset source clears the whole slave and the switch
  assign rst_all = reset_in | rst_hold_reg; // RULE_03
  // Inputs seen regardless of channel enable, usable as plain inputs
  assign irq_now = ~irq_sync_reg; // RULE_11 RULE_16

  //----------------------------------------------------------------------------
  // Upstream and downstream line repeaters
  //----------------------------------------------------------------------------
  logic                      sda_pull_reg;
  logic [CHANS-1:0]          sel_active_reg;
  wire logic                 scl_level;
  wire logic                 sda_level;

  line_repeater #(
    .CHANS        (CHANS)
  ) u_clk_rpt (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_all),
    .up_in        (up_scl_in),
    .local_low_in (1'b0),
    .dn_in        (down_clk_line_in),
    .en_in        (sel_active_reg),
    .up_oe_n_out  (up_scl_oe_n_out),
    .dn_oe_n_out  (down_clk_line_oe_n_out),
    .up_level_out (scl_level)
  );

  line_repeater #(
    .CHANS        (CHANS)
  ) u_dat_rpt (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_all),
    .up_in        (up_sda_in),
    .local_low_in (sda_pull_reg),
    .dn_in        (down_dat_line_in),
    .en_in        (sel_active_reg),
    .up_oe_n_out  (up_sda_oe_n_out),
    .dn_oe_n_out  (down_dat_line_oe_n_out),
    .up_level_out (sda_level)
  );

  // Open-drain pins only ever drive low
  assign up_scl_out        = 1'b0;
  assign up_sda_out        = 1'b0;
  assign down_clk_line_out = {CHANS{1'b0}};
  assign down_dat_line_out = {CHANS{1'b0}};

  //----------------------------------------------------------------------------
  // Bus condition detection
  //----------------------------------------------------------------------------
  logic                      scl_prev_reg;
  logic                      sda_prev_reg;
  wire logic                 scl_rise;
  wire logic                 scl_fall;
  wire logic                 start_seen;
  wire logic                 stop_seen;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_all)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_level;
      sda_prev_reg <= sda_level;
    end
  end

  assign scl_rise   = scl_level & ~scl_prev_reg;
  assign scl_fall   = ~scl_level & scl_prev_reg;
  assign start_seen = scl_level & scl_prev_reg & sda_prev_reg & ~sda_level;
  assign stop_seen  = scl_level & scl_prev_reg & ~sda_prev_reg & sda_level;

  //----------------------------------------------------------------------------
  // Serial slave
  //----------------------------------------------------------------------------
  switch_pkg::slave_state_t  state_reg;
  switch_pkg::slave_state_t  state_next;
  switch_pkg::ctrl_byte_t    ctrl_reg;
  switch_pkg::ctrl_byte_t    ctrl_next;
  logic [2:0]                bit_cnt_reg;
  logic [2:0]                bit_cnt_next;
  logic [7:0]                shift_reg;
  logic [7:0]                shift_next;
  logic                      byte_done_reg;
  logic                      byte_done_next;
  logic                      rw_reg;
  logic                      rw_next;
  logic                      nack_reg;
  logic                      nack_next;
  logic                      sel_dirty_reg;
  logic                      sel_dirty_next;
  logic [CHANS-1:0]          sel_active_next;
  logic                      sda_pull_next;
  wire logic [7:0]           rx_shift;
  wire logic [2:0]           bit_cnt_inc;
  wire logic                 last_bit;
  wire logic [7:0]           rd_byte;

  assign rx_shift    = {shift_reg[6:0], sda_level};
  assign bit_cnt_inc = bit_cnt_reg + 3'h1;
  assign last_bit    = bit_cnt_reg == switch_pkg::BIT_LAST;
  assign rd_byte     = {irq_now, ctrl_reg.chan_sel}; // RULE_12 RULE_13

  always_comb
  begin
    state_next      = state_reg;
    ctrl_next       = ctrl_reg;
    bit_cnt_next    = bit_cnt_reg;
    shift_next      = shift_reg;
    byte_done_next  = byte_done_reg;
    rw_next         = rw_reg;
    nack_next       = nack_reg;
    sel_dirty_next  = sel_dirty_reg;
    sel_active_next = sel_active_reg;
    if (start_seen)
    begin
      state_next     = switch_pkg::S_ADDR;
      bit_cnt_next   = switch_pkg::BIT_FIRST;
      byte_done_next = 1'b0;
    end
    else if (stop_seen)
    begin
      state_next = switch_pkg::S_IDLE;
      // Connecting only at STOP keeps every line high at switch-over
      if (sel_dirty_reg)
      begin
        sel_active_next = ctrl_reg.chan_sel; // RULE_10 RULE_09
        sel_dirty_next  = 1'b0;
      end
    end
    else
    begin
      case (state_reg)
        switch_pkg::S_IDLE:
          state_next = switch_pkg::S_IDLE;
        switch_pkg::S_ADDR, switch_pkg::S_WR_DATA:
        begin
          if (scl_rise)
          begin
            shift_next     = rx_shift;
            bit_cnt_next   = bit_cnt_inc;
            byte_done_next = last_bit;
          end
          else if (scl_fall && byte_done_reg)
          begin
            byte_done_next = 1'b0;
            if (state_reg == switch_pkg::S_WR_DATA)
            begin
              // Upper status bits are not writable
              ctrl_next.chan_sel = shift_reg[3:0]; // RULE_07 RULE_22 RULE_08
              sel_dirty_next     = 1'b1;
              state_next         = switch_pkg::S_WR_ACK;
            end
            else if (switch_pkg::addr_match(shift_reg[7:1],
                                            addr_sync_reg)) // RULE_21 RULE_05
            begin
              rw_next    = shift_reg[0]; // RULE_06
              state_next = switch_pkg::S_ADDR_ACK;
            end
            else
              state_next = switch_pkg::S_IDLE;
          end
        end
        switch_pkg::S_ADDR_ACK, switch_pkg::S_RD_ACK:
        begin
          if (scl_rise)
            nack_next = sda_level;
          else if (scl_fall)
          begin
            bit_cnt_next = switch_pkg::BIT_FIRST;
            if (state_reg == switch_pkg::S_ADDR_ACK &&
                rw_reg != switch_pkg::RW_READ)
              state_next = switch_pkg::S_WR_DATA;
            else if (state_reg == switch_pkg::S_RD_ACK && nack_reg)
              state_next = switch_pkg::S_IDLE;
            else
            begin
              // Inputs are caught once per byte, at its first bit
              ctrl_next.irq_stat = irq_now; // RULE_13
              shift_next         = rd_byte; // RULE_08
              state_next         = switch_pkg::S_RD_DATA;
            end
          end
        end
        switch_pkg::S_WR_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_next = switch_pkg::BIT_FIRST;
            state_next   = switch_pkg::S_WR_DATA;
          end
        end
        switch_pkg::S_RD_DATA:
        begin
          if (scl_rise)
          begin
            bit_cnt_next   = bit_cnt_inc;
            byte_done_next = last_bit;
          end
          else if (scl_fall)
          begin
            if (byte_done_reg)
            begin
              byte_done_next = 1'b0;
              state_next     = switch_pkg::S_RD_ACK;
            end
            else
              shift_next = {shift_reg[6:0], 1'b0};
          end
        end
        default:
          state_next = switch_pkg::S_IDLE;
      endcase
    end
  end

  // Data line pull follows the next state so it changes with SCL low
  always_comb
  begin
    case (state_next)
      switch_pkg::S_ADDR_ACK, switch_pkg::S_WR_ACK:
        sda_pull_next = 1'b1; // RULE_18
      switch_pkg::S_RD_DATA:
        sda_pull_next = ~shift_next[7];
      default:
        sda_pull_next = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_all)
    begin
      state_reg      <= switch_pkg::S_IDLE; // RULE_03
      ctrl_reg       <= switch_pkg::CTRL_RESET; // RULE_20
      sel_active_reg <= switch_pkg::SEL_NONE; // RULE_04 RULE_19
      bit_cnt_reg    <= switch_pkg::BIT_FIRST;
      shift_reg      <= 8'h00;
      byte_done_reg  <= 1'b0;
      rw_reg         <= 1'b0;
      nack_reg       <= 1'b0;
      sel_dirty_reg  <= 1'b0;
      sda_pull_reg   <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      ctrl_reg       <= ctrl_next;
      sel_active_reg <= sel_active_next;
      bit_cnt_reg    <= bit_cnt_next;
      shift_reg      <= shift_next;
      byte_done_reg  <= byte_done_next;
      rw_reg         <= rw_next;
      nack_reg       <= nack_next;
      sel_dirty_reg  <= sel_dirty_next;
      sda_pull_reg   <= sda_pull_next;
    end
  end

  //----------------------------------------------------------------------------
  // Combined interrupt output
  //----------------------------------------------------------------------------
  logic                      irq_oe_n_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_all)
      irq_oe_n_reg <= 1'b1;
    else
      irq_oe_n_reg <= &irq_sync_reg; // RULE_02 RULE_14
  end

  assign irq_n_out      = 1'b0;
  assign irq_oe_n_out   = irq_oe_n_reg;
  assign active_sel_out = sel_active_reg;

endmodule : i2c_four_channel_switch_ctrl

// ### sim/switch_props.sv
`timescale 1ns/1ns
module switch_props #(
  parameter int CHANS = 4
) (
  input wire logic             ref_clk_in,
  input wire logic             reset_in,
  input wire logic             rst_pin_n_in,
  input wire logic             irq_in_ch0_n_in,
  input wire logic             irq_in_ch1_n_in,
  input wire logic             irq_in_ch2_n_in,
  input wire logic             irq_in_ch3_n_in,
  input wire logic             up_scl_in,
  input wire logic             up_scl_oe_n_out,
  input wire logic             up_sda_in,
  input wire logic             up_sda_oe_n_out,
  input wire logic [CHANS-1:0] down_clk_line_oe_n_out,
  input wire logic [CHANS-1:0] down_dat_line_oe_n_out,
  input wire logic             irq_oe_n_out,
  input wire logic [CHANS-1:0] active_sel_out
);
  logic [3:0] irq_n;
  logic [3:0] stop_age_reg;
  logic       sda_prev_reg;
  assign irq_n = {irq_in_ch3_n_in, irq_in_ch2_n_in,
                  irq_in_ch1_n_in, irq_in_ch0_n_in};

  // Cycles since last STOP
  always_ff @(posedge ref_clk_in)
  begin
    sda_prev_reg <= up_sda_in;
    if (up_scl_in && up_sda_in && !sda_prev_reg)
      stop_age_reg <= 4'h0;
    else if (stop_age_reg != 4'hF)
      stop_age_reg <= stop_age_reg + 4'h1;
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  // Excludes a stretching channel
  sequence ch0_fall_s;
    active_sel_out[0] && up_scl_oe_n_out && $fell(up_scl_in);
  endsequence
  sequence idle_high_s;
    up_scl_in && $past(up_scl_in) && active_sel_out == '0;
  endsequence

  irq_low_a:
    assert property ((irq_n != 4'hF) [*5] |-> !irq_oe_n_out)
    else $error("irq not driven");
  irq_clear_a:
    assert property ((irq_n == 4'hF) [*5] |-> irq_oe_n_out)
    else $error("irq not released");
  reset_idle_a:
    assert property (disable iff (1'b0) reset_in |=> active_sel_out == '0
      && up_sda_oe_n_out && irq_oe_n_out && &down_clk_line_oe_n_out)
    else $error("not idle after reset");
  pin_reset_a:
    assert property (!rst_pin_n_in [*5] |=> active_sel_out == '0
      && up_sda_oe_n_out)
    else $error("pin reset kept sel");
  sel_after_stop_a:
    assert property ($changed(active_sel_out) && active_sel_out != '0
      |-> stop_age_reg <= 4'h8)
    else $error("sel change without stop");
  sda_steady_a:
    assert property (idle_high_s |-> $stable(up_sda_oe_n_out))
    else $error("sda moved in scl high");
  chan_follow_a:
    assert property (ch0_fall_s |-> ##[1:5] !down_clk_line_oe_n_out[0])
    else $error("scl low not passed");
  chan_off_a:
    assert property (&(down_clk_line_oe_n_out | active_sel_out
      | $past(active_sel_out)) && &(down_dat_line_oe_n_out
      | active_sel_out | $past(active_sel_out)))
    else $error("off channel driven");
endmodule : switch_props

bind i2c_four_channel_switch_ctrl switch_props #(.CHANS(CHANS)) props_i (
  .ref_clk_in, .reset_in, .rst_pin_n_in, .irq_in_ch0_n_in,
  .irq_in_ch1_n_in, .irq_in_ch2_n_in, .irq_in_ch3_n_in, .up_scl_in,
  .up_scl_oe_n_out, .up_sda_in, .up_sda_oe_n_out,
  .down_clk_line_oe_n_out, .down_dat_line_oe_n_out, .irq_oe_n_out,
  .active_sel_out
);

// ### sim/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
  input  wire logic sda_in,
  output logic      scl_out = 1'b1,
  output logic      sda_out = 1'b1
);
  // Quarter link period; clock idles high
  localparam int Q = 40;
  task automatic bit_xfer(input logic b, output logic r);
    #Q sda_out = b;
    #Q scl_out = 1'b1;
    #Q r = sda_in;
    #Q scl_out = 1'b0;
  endtask : bit_xfer
  task automatic start_cond();
    #Q sda_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_out = 1'b0;
    #Q scl_out = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    #Q sda_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_out = 1'b1;
    #Q;
  endtask : stop_cond
  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, ack_n);
  endtask : put_byte
  task automatic get_byte(input logic ack_n, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(ack_n, r);
  endtask : get_byte
endmodule : i2c_master_model

// ### sim/i2c_four_channel_switch_ctrl_tb.sv
`timescale 1ns/1ns
module i2c_four_channel_switch_ctrl_tb;
  logic       clk        = 1'b0;
  logic       rst        = 1'b1;
  logic       pin_n      = 1'b1;
  logic [1:0] pins       = 2'h2;
  logic [3:0] irq_n      = 4'hF;
  logic [3:0] dn_drv     = 4'hF;
  logic       m_scl;
  logic       m_sda;
  logic       scl_oe_n;
  logic       sda_oe_n;
  logic       irq_oe_n;
  logic [3:0] dclk_oe_n;
  logic [3:0] ddat_oe_n;
  logic [3:0] sel;
  wire        scl_w      = m_scl & scl_oe_n;
  wire        sda_w      = m_sda & sda_oe_n;
  int         n_mismatch = 0;
  int         tests_run  = 0;

  always #4 clk = ~clk;

  i2c_master_model mst (.sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));

  i2c_four_channel_switch_ctrl uut (
    .ref_clk_in(clk), .reset_in(rst), .rst_pin_n_in(pin_n),
    .addr_pin_lo_in(pins[0]), .addr_pin_hi_in(pins[1]),
    .irq_in_ch0_n_in(irq_n[0]), .irq_in_ch1_n_in(irq_n[1]),
    .irq_in_ch2_n_in(irq_n[2]), .irq_in_ch3_n_in(irq_n[3]),
    .up_scl_in(scl_w), .up_scl_out(), .up_scl_oe_n_out(scl_oe_n),
    .up_sda_in(sda_w), .up_sda_out(), .up_sda_oe_n_out(sda_oe_n),
    .down_clk_line_in(dclk_oe_n & dn_drv), .down_clk_line_out(),
    .down_clk_line_oe_n_out(dclk_oe_n),
    .down_dat_line_in(ddat_oe_n), .down_dat_line_out(),
    .down_dat_line_oe_n_out(ddat_oe_n),
    .irq_n_out(), .irq_oe_n_out(irq_oe_n), .active_sel_out(sel)
  );

  //--------------------------------------
  // Shared steps
  //--------------------------------------
  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic check(input string w, input logic [7:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", w, e, g);
      n_mismatch++;
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_sel(input logic [3:0] e);
    int k;
    k = 0;
    while (sel !== e && k < 20)
    begin
      cyc(1);
      k++;
    end
    check("active sel", {4'h0, e}, {4'h0, sel});
    if (sel !== e)
      conclude();
  endtask : wait_sel
  task automatic wr(input logic [7:0] d, input logic stop);
    logic a;
    mst.start_cond();
    mst.put_byte({switch_pkg::ADDR_FIXED, pins, 1'b0}, a);
    check("wr addr ack", 8'h00, {7'h0, a});
    mst.put_byte(d, a);
    check("data ack", 8'h00, {7'h0, a});
    if (stop)
    begin
      mst.stop_cond();
      wait_sel(d[3:0]);
    end
  endtask : wr
  task automatic rd(input logic [7:0] e, input string w);
    logic       a;
    logic [7:0] d;
    mst.start_cond();
    mst.put_byte({switch_pkg::ADDR_FIXED, pins, 1'b1}, a);
    check("rd addr ack", 8'h00, {7'h0, a});
    mst.get_byte(1'b1, d);
    mst.stop_cond();
    check(w, e, d);
  endtask : rd
  task automatic probe(input logic [6:0] a7, input logic e);
    logic a;
    mst.start_cond();
    mst.put_byte({a7, 1'b0}, a);
    mst.stop_cond();
    check("addr ack", {7'h0, e}, {7'h0, a});
  endtask : probe

  //--------------------------------------
  // Scenarios
  //--------------------------------------
  task automatic t_select();
    logic [27:0] tbl;
    logic [3:0]  p;
    logic [3:0]  s;
    tbl = 28'h12486F0;
    p = 4'h0;
    check("sel after reset", 8'h00, {4'h0, sel});
    rd(8'h00, "reg after reset");
    for (int i = 0; i < 7; i++)
    begin
      s = tbl[27-4*i -: 4];
      wr({4'hA, s}, 1'b0);
      check("sel before stop", {4'h0, p}, {4'h0, sel});
      mst.stop_cond();
      wait_sel(s);
      rd({4'h0, s}, "read back");
      p = s;
    end
    wr(8'h03, 1'b0);
    wr(8'h0C, 1'b1);
  endtask : t_select
  task automatic t_address();
    for (int p = 0; p < 4; p++)
    begin
      pins = 2'(p);
      cyc(4);
      probe({switch_pkg::ADDR_FIXED, pins ^ 2'h1}, 1'b1);
      probe({switch_pkg::ADDR_FIXED ^ 5'h01, pins}, 1'b1);
      probe({switch_pkg::ADDR_FIXED, pins}, 1'b0);
    end
    check("sel kept", 8'h0C, {4'h0, sel});
  endtask : t_address
  task automatic t_irq();
    logic [3:0] cur;
    logic [3:0] b;
    cur = 4'h8;
    wr({4'h0, cur}, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      b = 4'h1 << i;
      irq_n = ~b;
      cyc(6);
      check("irq output", 8'h00, {7'h0, irq_oe_n});
      rd({b, cur}, "irq status");
      irq_n = 4'hF;
      wr({4'h0, b}, 1'b1);
      cur = b;
    end
    irq_n = 4'h6;
    cyc(6);
    rd({4'h9, cur}, "two irqs");
    irq_n = 4'hF;
    cyc(6);
    check("irq released", 8'h01, {7'h0, irq_oe_n});
    rd({4'h0, cur}, "no irq");
  endtask : t_irq
  task automatic t_stretch();
    dn_drv = 4'hE;
    cyc(10);
    check("off chan low", 8'h01, {7'h0, scl_oe_n});
    dn_drv = 4'h7;
    cyc(10);
    check("on chan low", 8'h00, {7'h0, scl_oe_n});
    dn_drv = 4'hF;
    cyc(10);
  endtask : t_stretch
  task automatic t_resets();
    wr(8'h05, 1'b1);
    pin_n = 1'b0;
    cyc(6);
    pin_n = 1'b1;
    cyc(10);
    check("sel after pin", 8'h00, {4'h0, sel});
    rd(8'h00, "reg after pin");
    wr(8'h0A, 1'b1);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(10);
    check("sel after sync reset", 8'h00, {4'h0, sel});
    rd(8'h00, "reg after sync reset");
  endtask : t_resets

  initial
  begin
    #700000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    cyc(8);
    rst = 1'b0;
    cyc(10);
    t_select();
    t_address();
    t_irq();
    t_stretch();
    t_resets();
    conclude();
  end
endmodule : i2c_four_channel_switch_ctrl_tb
